//--- sirqm_defines.vh
// register map, field positions and reset values of the serial irq mask block
`ifndef SIRQM_DEFINES_VH
`define SIRQM_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SIRQM_ADDR_STATUS       32'hFFF9C040
`define SIRQM_ADDR_ENABLE       32'hFFF9C044
`define SIRQM_ADDR_DISABLE      32'hFFF9C048
`define SIRQM_ADDR_MASK         32'hFFF9C04C

// ----------------------------------------------------------------
// source and enable bit positions
// ----------------------------------------------------------------
`define SIRQM_BIT_TX_HOLD_FREE  0
`define SIRQM_BIT_TX_ALL_DONE   1
`define SIRQM_BIT_TX_CNT_DONE   2
`define SIRQM_BIT_TX_BUF_EXH    3
`define SIRQM_BIT_RX_WORD_AVL   4
`define SIRQM_BIT_RX_OVERRUN    5
`define SIRQM_BIT_RX_CNT_DONE   6
`define SIRQM_BIT_RX_BUF_EXH    7
`define SIRQM_BIT_CMP_ZERO      8
`define SIRQM_BIT_CMP_ONE       9
`define SIRQM_BIT_TX_SYNC       10
`define SIRQM_BIT_RX_SYNC       11
`define SIRQM_BIT_TX_ENABLED    16
`define SIRQM_BIT_RX_ENABLED    17

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define SIRQM_SRC_W             12
`define SIRQM_STICKY_W          5
`define SIRQM_MASK_RESET        12'h000
`define SIRQM_STICKY_RESET      5'h00
`define SIRQM_DATA_RESET        32'h00000000

`endif

//--- sirqm_sticky.v
// sticky event flags: set by hardware, cleared by software, set wins
`timescale 1ns/1ps

module sirqm_sticky #(
    parameter WIDTH = 5
) (
    input  wire             mclk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] set_in,
    input  wire [WIDTH-1:0] clr_in,
    output wire [WIDTH-1:0] flag_out
);

// ----------------------------------------------------------------
// flag storage
// ----------------------------------------------------------------
reg  [WIDTH-1:0] flag_ff;
reg  [WIDTH-1:0] nxt_flag;

always @* begin
    // a set in the clear cycle is kept
    nxt_flag = (flag_ff & ~clr_in) | set_in;
end

always @(posedge mclk) begin
    if (!rst_n) begin
        flag_ff <= {WIDTH{1'b0}};
    end else begin
        flag_ff <= nxt_flag;
    end
end

assign flag_out = flag_ff;

endmodule // sirqm_sticky

//--- sirqm_top.v
// interrupt mask logic of the serial controller with its apb slave
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "sirqm_defines.vh"

module sirqm_top (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [31:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        tx_holding_free,
    input  wire        tx_all_done,
    input  wire        tx_count_done,
    input  wire        tx_buffers_exhausted,
    input  wire        rx_word_available,
    input  wire        rx_overrun,
    input  wire        rx_count_done,
    input  wire        rx_buffers_exhausted,
    input  wire        compare_zero_hit,
    input  wire        compare_one_hit,
    input  wire        tx_frame_sync_seen,
    input  wire        rx_frame_sync_seen,
    input  wire        tx_enabled,
    input  wire        rx_enabled,
    output wire        irq
);

// ----------------------------------------------------------------
// local constants
// ----------------------------------------------------------------
localparam SRC_W    = `SIRQM_SRC_W;
localparam STICKY_W = `SIRQM_STICKY_W;

// sticky vector slots
localparam SLOT_OVR = 0;
localparam SLOT_CP0 = 1;
localparam SLOT_CP1 = 2;
localparam SLOT_TXS = 3;
localparam SLOT_RXS = 4;

// ----------------------------------------------------------------
// registers and nets
// ----------------------------------------------------------------
reg  [SRC_W-1:0]    mask_ff;
reg  [SRC_W-1:0]    nxt_mask;
reg  [31:0]         prdata_ff;
reg  [31:0]         nxt_prdata;
reg                 pready_ff;
reg                 nxt_pready;
reg                 pslverr_ff;
reg                 nxt_pslverr;
reg                 irq_ff;
reg                 nxt_irq;
reg                 rd_status_ff;
reg                 nxt_rd_status;

wire                setup_phase;
wire                access_done;
wire                wr_done;
wire                rd_done;
wire                hit_status;
wire                hit_enable;
wire                hit_disable;
wire                hit_mask;
wire                hit_any;
wire [31:0]         lane_mask;
wire [31:0]         wdata_eff;
wire [SRC_W-1:0]    wr_bits;
wire [STICKY_W-1:0] sticky_set;
wire [STICKY_W-1:0] sticky_clr;
wire [STICKY_W-1:0] sticky_rd_clr;
wire [STICKY_W-1:0] sticky_w1c;
wire [STICKY_W-1:0] sticky_flags;
wire [STICKY_W-1:0] sticky_seen;
reg  [SRC_W-1:0]    live_flags;
reg  [31:0]         status_word;

// ----------------------------------------------------------------
// apb phase decode
// ----------------------------------------------------------------
assign setup_phase = psel & ~penable;
assign access_done = psel & penable & pready_ff;
assign wr_done     = access_done & pwrite;
assign rd_done     = access_done & ~pwrite;

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
assign hit_status  = (paddr == `SIRQM_ADDR_STATUS);
assign hit_enable  = (paddr == `SIRQM_ADDR_ENABLE);
assign hit_disable = (paddr == `SIRQM_ADDR_DISABLE);
assign hit_mask    = (paddr == `SIRQM_ADDR_MASK);
assign hit_any     = hit_status | hit_enable | hit_disable | hit_mask;

// ----------------------------------------------------------------
// byte lane gating of write data
// ----------------------------------------------------------------
assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};
assign wdata_eff = pwdata & lane_mask;
assign wr_bits   = wdata_eff[SRC_W-1:0];

// ----------------------------------------------------------------
// event sources into sticky slots
// ----------------------------------------------------------------
assign sticky_set[SLOT_OVR] = rx_overrun;
assign sticky_set[SLOT_CP0] = compare_zero_hit;
assign sticky_set[SLOT_CP1] = compare_one_hit;
assign sticky_set[SLOT_TXS] = tx_frame_sync_seen;
assign sticky_set[SLOT_RXS] = rx_frame_sync_seen;

// ----------------------------------------------------------------
// sticky clear: status read or write of ones
// ----------------------------------------------------------------
// only flags that the read actually returned are dropped
assign sticky_seen[SLOT_OVR] = prdata_ff[`SIRQM_BIT_RX_OVERRUN];
assign sticky_seen[SLOT_CP0] = prdata_ff[`SIRQM_BIT_CMP_ZERO];
assign sticky_seen[SLOT_CP1] = prdata_ff[`SIRQM_BIT_CMP_ONE];
assign sticky_seen[SLOT_TXS] = prdata_ff[`SIRQM_BIT_TX_SYNC];
assign sticky_seen[SLOT_RXS] = prdata_ff[`SIRQM_BIT_RX_SYNC];

assign sticky_rd_clr = (rd_done & rd_status_ff) ?
                       sticky_seen : {STICKY_W{1'b0}};

assign sticky_w1c[SLOT_OVR] = wr_bits[`SIRQM_BIT_RX_OVERRUN];
assign sticky_w1c[SLOT_CP0] = wr_bits[`SIRQM_BIT_CMP_ZERO];
assign sticky_w1c[SLOT_CP1] = wr_bits[`SIRQM_BIT_CMP_ONE];
assign sticky_w1c[SLOT_TXS] = wr_bits[`SIRQM_BIT_TX_SYNC];
assign sticky_w1c[SLOT_RXS] = wr_bits[`SIRQM_BIT_RX_SYNC];

assign sticky_clr = sticky_rd_clr |
                    ((wr_done & hit_status) ?
                     sticky_w1c : {STICKY_W{1'b0}});

sirqm_sticky #(
    .WIDTH    (STICKY_W)
) u_sticky (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .set_in   (sticky_set),
    .clr_in   (sticky_clr),
    .flag_out (sticky_flags)
);

// ----------------------------------------------------------------
// status flag vector
// ----------------------------------------------------------------
always @* begin
    live_flags = {SRC_W{1'b0}};
    live_flags[`SIRQM_BIT_TX_HOLD_FREE] = tx_holding_free;
    live_flags[`SIRQM_BIT_TX_ALL_DONE]  = tx_all_done;
    live_flags[`SIRQM_BIT_TX_CNT_DONE]  = tx_count_done;
    live_flags[`SIRQM_BIT_TX_BUF_EXH]   = tx_buffers_exhausted;
    live_flags[`SIRQM_BIT_RX_WORD_AVL]  = rx_word_available;
    live_flags[`SIRQM_BIT_RX_OVERRUN]   = sticky_flags[SLOT_OVR];
    live_flags[`SIRQM_BIT_RX_CNT_DONE]  = rx_count_done;
    live_flags[`SIRQM_BIT_RX_BUF_EXH]   = rx_buffers_exhausted;
    live_flags[`SIRQM_BIT_CMP_ZERO]     = sticky_flags[SLOT_CP0];
    live_flags[`SIRQM_BIT_CMP_ONE]      = sticky_flags[SLOT_CP1];
    live_flags[`SIRQM_BIT_TX_SYNC]      = sticky_flags[SLOT_TXS];
    live_flags[`SIRQM_BIT_RX_SYNC]      = sticky_flags[SLOT_RXS];
end

always @* begin
    status_word = `SIRQM_DATA_RESET;
    status_word[SRC_W-1:0] = live_flags;
    status_word[`SIRQM_BIT_TX_ENABLED] = tx_enabled;
    status_word[`SIRQM_BIT_RX_ENABLED] = rx_enabled;
end

// ----------------------------------------------------------------
// mask register update
// ----------------------------------------------------------------
always @* begin
    nxt_mask = mask_ff;
    if (wr_done && hit_enable) begin
        nxt_mask = mask_ff | wr_bits;
    end else if (wr_done && hit_disable) begin
        nxt_mask = mask_ff & ~wr_bits;
    end
end

always @(posedge mclk) begin
    if (!rst_n) begin
        mask_ff <= `SIRQM_MASK_RESET;
    end else begin
        mask_ff <= nxt_mask;
    end
end

// ----------------------------------------------------------------
// apb answer: one access cycle, data set up in setup cycle
// ----------------------------------------------------------------
always @* begin
    nxt_pready    = 1'b0;
    nxt_pslverr   = 1'b0;
    nxt_prdata    = `SIRQM_DATA_RESET;
    nxt_rd_status = 1'b0;
    if (setup_phase) begin
        nxt_pready  = 1'b1;
        nxt_pslverr = ~hit_any;
        if (!pwrite) begin
            nxt_rd_status = hit_status;
            if (hit_status) begin
                nxt_prdata = status_word;
            end else if (hit_mask) begin
                nxt_prdata[SRC_W-1:0] = mask_ff;
            end
        end
    end else if (psel && penable && !pready_ff) begin
        // stray access phase without setup: error answer in the next cycle
        nxt_pready  = 1'b1;
        nxt_pslverr = 1'b1;
    end
end

always @(posedge mclk) begin
    if (!rst_n) begin
        pready_ff    <= 1'b0;
        pslverr_ff   <= 1'b0;
        prdata_ff    <= `SIRQM_DATA_RESET;
        rd_status_ff <= 1'b0;
    end else begin
        pready_ff    <= nxt_pready;
        pslverr_ff   <= nxt_pslverr;
        prdata_ff    <= nxt_prdata;
        rd_status_ff <= nxt_rd_status;
    end
end

// ----------------------------------------------------------------
// interrupt request
// ----------------------------------------------------------------
always @* begin
    nxt_irq = |(live_flags & mask_ff);
end

always @(posedge mclk) begin
    if (!rst_n) begin
        irq_ff <= 1'b0;
    end else begin
        irq_ff <= nxt_irq;
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign prdata  = prdata_ff;
assign pready  = pready_ff;
assign pslverr = pslverr_ff;
assign irq     = irq_ff;

endmodule // sirqm_top

//--- sirqm_chk.sv
// assertion checker of the serial irq mask block
`timescale 1ns/1ps
module sirqm_chk (
    input wire        mclk,
    input wire        rst_n,
    input wire [31:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        compare_zero_hit,
    input wire        irq
);
    // ----------------
    // shadow mask
    // ----------------
    reg  [11:0] msk_ff;
    wire        fin = psel && penable && pready;
    wire        map = paddr[31:4] == 28'hFFF9C04 && paddr[1:0] == 2'h0;
    wire [11:0] wd = pwdata[11:0] & {{4{pstrb[1]}}, {8{pstrb[0]}}};
    always @(posedge mclk) begin
        if (!rst_n)
            msk_ff <= 12'h000;
        else if (fin && pwrite && paddr == 32'hFFF9C044)
            msk_ff <= msk_ff | wd;
        else if (fin && pwrite && paddr == 32'hFFF9C048)
            msk_ff <= msk_ff & ~wd;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_bad_addr: assert property (psel && !penable && !map |=> pslverr)
        else $error("no pslverr");
    a_good_addr: assert property (psel && !penable && map |=> !pslverr)
        else $error("false pslverr");
    a_mask_read: assert property (
        fin && !pwrite && paddr == 32'hFFF9C04C |-> prdata == {20'h0, msk_ff})
        else $error("mask read");
    a_irq_event: assert property (
        $past(compare_zero_hit) && msk_ff[8] |=> irq) else $error("no irq");
    a_irq_off: assert property (msk_ff == 12'h000 |=> !irq)
        else $error("irq unmasked");
    a_reset_idle: assert property (disable iff (1'b0)
        !rst_n |=> !pready && !pslverr && !irq) else $error("reset busy");
    c_enable: cover property (fin && pwrite && paddr == 32'hFFF9C044);
    c_irq: cover property (irq);
    c_error: cover property (pready && pslverr);
endmodule // sirqm_chk
bind sirqm_top sirqm_chk u_chk (.mclk(mclk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_zero_hit(compare_zero_hit), .irq(irq));

//--- testbench.sv
// self-checking testbench of the serial irq mask block
`timescale 1ns/1ps
module testbench;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [31:0] paddr = 32'h0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [31:0] pwdata = 32'h0;
    reg  [3:0]  pstrb = 4'h0;
    reg  [11:0] src = 12'h000;
    reg  [1:0]  ena = 2'h0;
    reg  [3:0]  s = 4'hF;
    reg  [31:0] d;
    reg  [11:0] g;
    reg  [11:0] msk;
    reg  [32:0] e;
    reg  [32:0] expq[$];
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        irq;
    integer     n_fail = 0;
    integer     num_checks = 0;
    integer     i;
    sirqm_top dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .tx_holding_free(src[0]), .tx_all_done(src[1]),
        .tx_count_done(src[2]), .tx_buffers_exhausted(src[3]),
        .rx_word_available(src[4]), .rx_overrun(src[5]),
        .rx_count_done(src[6]), .rx_buffers_exhausted(src[7]),
        .compare_zero_hit(src[8]), .compare_one_hit(src[9]),
        .tx_frame_sync_seen(src[10]), .rx_frame_sync_seen(src[11]),
        .tx_enabled(ena[0]), .rx_enabled(ena[1]));
    initial forever #5 mclk = ~mclk;
    task chk(input string n, input [31:0] x, input [31:0] v);
        num_checks = num_checks + 1;
        if (x !== v) begin
            n_fail = n_fail + 1;
            $display("ERROR %s exp %h got %h", n, x, v);
        end
    endtask
    task ci(input b);
        chk("irq", {31'h0, b}, {31'h0, irq});
    endtask
    task test_done;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task xfer(input [7:0] a, input w, input [31:0] dv, input err);
        expq.push_back({err, dv});
        paddr <= {24'hFFF9C0, a};
        pwrite <= w;
        pwdata <= dv;
        pstrb <= w ? s : 4'h0;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    always @(posedge mclk)
        if (psel && penable && pready === 1'b1) begin
            e = expq.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (!pwrite)
                chk("prdata", e[31:0], prdata);
        end
    initial begin
        d = $urandom(3623);
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        ci(1'b0);
        xfer(8'h4C, 1'b0, 32'h0, 1'b0);
        xfer(8'h50, 1'b0, 32'h0, 1'b1);
        xfer(8'h50, 1'b1, 32'h0, 1'b1);
        for (i = 0; i < 12; i = i + 1) begin
            ena <= i[1:0];
            xfer(8'h48, 1'b1, 32'hFFF, 1'b0);
            xfer(8'h44, 1'b1, 32'hFFF ^ (32'h1 << i), 1'b0);
            src <= 12'h001 << i;
            repeat (4) @(posedge mclk);
            ci(1'b0);
            xfer(8'h44, 1'b1, 32'h1 << i, 1'b0);
            repeat (3) @(posedge mclk);
            ci(1'b1);
            d = {14'h0, ena, 4'h0, src & 12'hF20};
            src <= 12'h000;
            repeat (4) @(posedge mclk);
            ci(|d[11:0]);
            xfer(8'h40, 1'b0, d, 1'b0);
            xfer(8'h40, 1'b0, d & 32'h30000, 1'b0);
            ci(1'b0);
        end
        msk = 12'h000;
        xfer(8'h48, 1'b1, 32'hFFF, 1'b0);
        for (i = 0; i < 24; i = i + 1) begin
            d = $urandom;
            s = d[27:24];
            g = d[11:0] & {{4{s[1]}}, {8{s[0]}}};
            msk = d[31] ? msk | g : msk & ~g;
            xfer(d[31] ? 8'h44 : 8'h48, 1'b1, d, 1'b0);
            s = 4'hF;
            xfer(8'h4C, 1'b0, {20'h0, msk}, 1'b0);
        end
        xfer(8'h4C, 1'b1, 32'hFFF, 1'b0);
        xfer(8'h4C, 1'b0, {20'h0, msk}, 1'b0);
        xfer(8'h44, 1'b0, 32'h0, 1'b0);
        xfer(8'h48, 1'b0, 32'h0, 1'b0);
        // event held across a status read: set wins
        src <= 12'h100;
        @(posedge mclk);
        xfer(8'h40, 1'b0, {14'h0, ena, 16'h0100}, 1'b0);
        xfer(8'h40, 1'b0, {14'h0, ena, 16'h0100}, 1'b0);
        src <= 12'h000;
        @(posedge mclk);
        xfer(8'h40, 1'b1, 32'h100, 1'b0);
        xfer(8'h40, 1'b0, {14'h0, ena, 16'h0000}, 1'b0);
        // access phase without setup gets an error answer
        expq.push_back(33'h100000000);
        paddr <= 32'hFFF9C050;
        pwrite <= 1'b0;
        psel <= 1'b1;
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        // second reset in mid-run clears mask and flags
        xfer(8'h44, 1'b1, 32'hFFF, 1'b0);
        src <= 12'h800;
        @(posedge mclk);
        src <= 12'h000;
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        ci(1'b0);
        xfer(8'h4C, 1'b0, 32'h0, 1'b0);
        xfer(8'h40, 1'b0, {14'h0, ena, 16'h0000}, 1'b0);
        test_done;
    end
    initial begin
        #100000 n_fail = n_fail + 1;
        test_done;
    end
endmodule // testbench
